// File: hw/mcs_regs.svh
// Purpose: Register offsets, field positions and reset values of the modem control/status block
// Assumes: 3-bit register address on the processor bus
// Notes:   Definitions only
`ifndef MCS_REGS_SVH
`define MCS_REGS_SVH

// ==================================================
// Register offsets
`define MCS_OFS_MODEM_CONTROL 3'h4
`define MCS_OFS_MODEM_STATUS  3'h6

// ==================================================
// Modem control fields
`define MCS_MCR_TERM_READY    0
`define MCS_MCR_SEND_REQ      1
`define MCS_MCR_USER_A        2
`define MCS_MCR_USER_B        3
`define MCS_MCR_LOOP          4
`define MCS_MCR_WIDTH         5
`define MCS_MCR_RESET         5'h00

// ==================================================
// Modem status fields
`define MCS_MSR_SEND_CLEAR_CHG 0
`define MCS_MSR_SET_READY_CHG  1
`define MCS_MSR_RING_END       2
`define MCS_MSR_CARRIER_CHG    3
`define MCS_MSR_FLAGS_RESET    4'h0

// ==================================================
// Interrupt identification codes
`define MCS_IID_MODEM 3'h0
`define MCS_IID_NONE  3'h1

`endif

// File: hw/mcs_pkg.sv
// Purpose: Shared types of the modem control/status block
// Assumes: Nothing
// Notes:   Constants live in mcs_regs.svh
package mcs_pkg;
   typedef logic [7:0] mcs_byte_t;

   // Register selected by the current bus access
   typedef enum logic [1:0] {
      MCS_SEL_NONE    = 2'b00,
      MCS_SEL_CONTROL = 2'b01,
      MCS_SEL_STATUS  = 2'b10
   } mcs_sel_t;

   // Line states, active high, in status register order (bit 7 down to 4)
   typedef struct packed {
      logic carrier;
      logic ring;
      logic setReady;
      logic sendClear;
   } mcs_lines_t;
endpackage : mcs_pkg

// File: hw/mcs_flag_if.sv
// Purpose: Carrier between the register block and its change-flag keeper
// Assumes: Single clock domain
// Notes:   One event bit per flag
`timescale 1ns/1ps
interface mcs_flag_if #(parameter int W = 4);
   logic [W-1:0] events;
   logic         readActive;
   logic         readEnd;
   logic [W-1:0] flags;

   modport keeper (input events, input readActive, input readEnd, output flags);
   modport user   (output events, output readActive, output readEnd, input flags);
endinterface : mcs_flag_if

// File: hw/mcs_change_flags.sv
// Purpose: Sticky change flags with defined behaviour around a status read
// Assumes: readActive high for the whole read, readEnd one cycle after it drops
// Notes:   Events seen during a read are parked and settled at the trailing edge
`timescale 1ns/1ps
module mcs_change_flags
   import mcs_pkg::*;
#(
   parameter int W = 4
) (
   // Clock and reset
   input wire logic   mclk,
   input wire logic   sys_rst,
   // Flag carrier
   mcs_flag_if.keeper fl
);
`include "mcs_regs.svh"

   logic [W-1:0] flagQ;
   logic [W-1:0] parked;

   assign fl.flags = flagQ;

   // ==================================================
   // Per-flag state
   genvar i;
   generate
      for (i = 0; i < W; i++) begin : g_flag
         always_ff @(posedge mclk or posedge sys_rst) begin
            if (sys_rst) begin
               parked[i] <= 1'b0;
            end else if (fl.readEnd) begin
               parked[i] <= 1'b0;
            end else if (fl.readActive && fl.events[i]) begin
               parked[i] <= 1'b1;
            end
         end

         always_ff @(posedge mclk or posedge sys_rst) begin
            if (sys_rst) begin
               flagQ[i] <= 1'b0;
            end else if (fl.readEnd) begin
               // A set flag hit again is cleared, a clear flag hit is set
               flagQ[i] <= (parked[i] | fl.events[i]) & ~flagQ[i];
            end else if (!fl.readActive) begin
               flagQ[i] <= flagQ[i] | fl.events[i];
            end
         end
      end
   endgenerate
endmodule : mcs_change_flags

// File: hw/mcs_modem_control_status.sv
// Purpose: Modem handshake section: control register, status register, loopback, modem interrupt
// Assumes: Bus strobes and all pins synchronous to mclk; address stable while a strobe is high
// Notes:   Handshake and serial outputs are registered, one cycle behind their cause
//
// What this block does
// - Control bits 0,1 drive ready/request low
// - Control bits 2,3 drive user outputs low
// - Control register read/write, top bits zero
// - Loopback: transmit pin marks, receive pin ignored
// - Loopback: transmitter output feeds receiver input
// - Loopback: status lines follow control bits
// - Loopback: handshake output pins held high
// - Loopback: modem interrupt from control bits
// - Status bits 4-7 show inverted pins
// - Send-clear, set-ready and carrier flags set on either edge
// - Ring flag only on pin rising
// - Status read clears flags, not lines
// - Enabled flag raises modem interrupt, code zero
// - Line bits ignore any interrupt enable
// - Set flag: change during read dropped
// - Clear flag: change during read set after
// - Read-time conditions set at trailing edge
// - Set bit recurring during read clears
// - Modem interrupt ranks lowest of four
`timescale 1ns/1ps
module mcs_modem_control_status
   import mcs_pkg::*;
(
   // Clock and reset
   input  wire logic       mclk,
   input  wire logic       sys_rst,
   // Processor bus
   input  wire logic       chipSel,
   input  wire logic [2:0] regAddr,
   input  wire logic       writeStrobe,
   input  wire logic       readStrobe,
   input  wire mcs_byte_t  writeData,
   output mcs_byte_t       readData,
   // Modem input pins, active low
   input  wire logic       clearToSend_n,
   input  wire logic       setReady_n,
   input  wire logic       phoneCallSenseIn_n,
   input  wire logic       carrierDetectIn_n,
   // Modem output pins, active low
   output logic            termReady_n,
   output logic            sendRequest_n,
   output logic            userOutputA_n,
   output logic            userOutputB_n,
   // Serial path
   input  wire logic       txShiftOut,
   input  wire logic       serialRxLine,
   output logic            serialTxLine,
   output logic            rxShiftIn,
   // Interrupt connections
   input  wire logic       modemIrqEnable,
   input  wire logic [2:0] higherIrqPending,
   output logic            irqOut,
   output logic [2:0]      irqIdent
);
`include "mcs_regs.svh"

   // ==================================================
   // Address decode
   function automatic mcs_sel_t decodeSel(input logic cs, input logic [2:0] addr);
      mcs_sel_t s;
      s = MCS_SEL_NONE;
      if (cs && addr == `MCS_OFS_MODEM_CONTROL) begin
         s = MCS_SEL_CONTROL;
      end else if (cs && addr == `MCS_OFS_MODEM_STATUS) begin
         s = MCS_SEL_STATUS;
      end
      return s;
   endfunction : decodeSel

   logic [`MCS_MCR_WIDTH-1:0] modemControl;
   mcs_lines_t                 pinLines;
   mcs_lines_t                 loopLines;
   mcs_lines_t                 lines;
   mcs_lines_t                 linesQ;
   logic                       linesPrimed;
   logic                       loopOn;
   logic                       statusRead;
   logic                       statusReadQ;
   logic [3:0]                 changeEvents;
   logic [3:0]                 changeFlags;
   logic                       modemIrq;

   mcs_flag_if #(.W(4)) flagBus ();

   assign loopOn     = modemControl[`MCS_MCR_LOOP];
   assign statusRead = readStrobe && decodeSel(chipSel, regAddr) == MCS_SEL_STATUS;

   // ==================================================
   // Control register
   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         modemControl <= `MCS_MCR_RESET;
      end else if (writeStrobe && decodeSel(chipSel, regAddr) == MCS_SEL_CONTROL) begin
         modemControl <= writeData[`MCS_MCR_WIDTH-1:0];
      end
   end

   // ==================================================
   // Handshake output pins
   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         termReady_n   <= 1'b1;
         sendRequest_n <= 1'b1;
         userOutputA_n <= 1'b1;
         userOutputB_n <= 1'b1;
      end else begin
         termReady_n   <= loopOn | ~modemControl[`MCS_MCR_TERM_READY];
         sendRequest_n <= loopOn | ~modemControl[`MCS_MCR_SEND_REQ];
         userOutputA_n <= loopOn | ~modemControl[`MCS_MCR_USER_A];
         userOutputB_n <= loopOn | ~modemControl[`MCS_MCR_USER_B];
      end
   end

   // ==================================================
   // Serial path and loopback
   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         serialTxLine <= 1'b1;
         rxShiftIn    <= 1'b1;
      end else begin
         serialTxLine <= loopOn ? 1'b1 : txShiftOut;
         rxShiftIn    <= loopOn ? txShiftOut : serialRxLine;
      end
   end

   // ==================================================
   // Modem lines, active high
   assign pinLines  = ~{carrierDetectIn_n, phoneCallSenseIn_n, setReady_n, clearToSend_n};
   assign loopLines = {modemControl[`MCS_MCR_USER_B], modemControl[`MCS_MCR_USER_A],
                       modemControl[`MCS_MCR_TERM_READY], modemControl[`MCS_MCR_SEND_REQ]};
   assign lines     = loopOn ? loopLines : pinLines;

   // Line bits track continuously; no enable or read gates them
   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         linesQ      <= '0;
         linesPrimed <= 1'b0;
      end else begin
         linesQ      <= lines;
         linesPrimed <= 1'b1;
      end
   end

   // The first sample after reset is not a change
   always_comb begin
      changeEvents = '0;
      if (linesPrimed) begin
         changeEvents[`MCS_MSR_SEND_CLEAR_CHG] = lines.sendClear ^ linesQ.sendClear;
         changeEvents[`MCS_MSR_SET_READY_CHG]  = lines.setReady ^ linesQ.setReady;
         changeEvents[`MCS_MSR_CARRIER_CHG]    = lines.carrier ^ linesQ.carrier;
         // Pin low to high is the line bit going from one to zero
         changeEvents[`MCS_MSR_RING_END]       = linesQ.ring & ~lines.ring;
      end
   end

   // ==================================================
   // Status read framing and change flags
   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         statusReadQ <= 1'b0;
      end else begin
         statusReadQ <= statusRead;
      end
   end

   assign flagBus.events     = changeEvents;
   assign flagBus.readActive = statusRead;
   assign flagBus.readEnd    = statusReadQ & ~statusRead;
   assign changeFlags        = flagBus.flags;

   mcs_change_flags #(.W(4)) u_flags (
      .mclk    (mclk),
      .sys_rst (sys_rst),
      .fl      (flagBus)
   );

   // ==================================================
   // Read data, reloaded in every strobe cycle and held once the strobe drops
   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         readData <= 8'h00;
      end else if (readStrobe) begin
         unique case (decodeSel(chipSel, regAddr))
            MCS_SEL_CONTROL: readData <= {3'h0, modemControl};
            MCS_SEL_STATUS:  readData <= {linesQ, changeFlags};
            MCS_SEL_NONE:    readData <= 8'h00;
         endcase
      end
   end

   // ==================================================
   // Modem interrupt, lowest of the four sources
   assign modemIrq = modemIrqEnable & (|changeFlags);
   assign irqOut   = modemIrq;
   assign irqIdent = (modemIrq && higherIrqPending == 3'h0) ? `MCS_IID_MODEM : `MCS_IID_NONE;

   // ==================================================
   // Checks
   default clocking cb @(posedge mclk); endclocking
   default disable iff (sys_rst);

   term_ready_drive_a: assert property (
      (modemControl[`MCS_MCR_TERM_READY] && !loopOn) |=> !termReady_n)
      else $error("terminal ready not driven low");
   user_out_drive_a: assert property (
      (!modemControl[`MCS_MCR_USER_A] && !modemControl[`MCS_MCR_USER_B]) |=> userOutputA_n && userOutputB_n)
      else $error("user outputs not high when cleared");
   control_upper_zero_a: assert property (
      (readStrobe && decodeSel(chipSel, regAddr) == MCS_SEL_CONTROL) |=> readData[7:5] == 3'h0
         && readData[4:0] == $past(modemControl))
      else $error("control readback wrong");
   loop_tx_mark_a: assert property (
      loopOn |=> serialTxLine)
      else $error("transmit pin not marking in loopback");
   loop_rx_feed_a: assert property (
      loopOn |=> rxShiftIn == $past(txShiftOut))
      else $error("loopback receive path wrong");
   loop_status_map_a: assert property (
      loopOn |=> linesQ.sendClear == $past(modemControl[`MCS_MCR_SEND_REQ])
         && linesQ.carrier == $past(modemControl[`MCS_MCR_USER_B]))
      else $error("loopback status mapping wrong");
   loop_pins_idle_a: assert property (
      loopOn [*2] |-> termReady_n && sendRequest_n && userOutputA_n && userOutputB_n)
      else $error("handshake pins active in loopback");
   ring_rise_only_a: assert property (
      (!statusRead && !statusReadQ && !changeFlags[`MCS_MSR_RING_END] && !(linesQ.ring && !lines.ring))
         |=> !changeFlags[`MCS_MSR_RING_END])
      else $error("ring flag set without pin rising");
   read_hold_a: assert property (
      (statusRead && $past(statusRead)) |-> $stable(changeFlags))
      else $error("flags moved during status read");
   recur_clears_a: assert property (
      (flagBus.readEnd && changeFlags[`MCS_MSR_CARRIER_CHG]) |=> !changeFlags[`MCS_MSR_CARRIER_CHG])
      else $error("set flag survived read end");
   modem_irq_a: assert property (
      (modemIrqEnable && changeFlags != 4'h0) |-> irqOut
         && (higherIrqPending != 3'h0 || irqIdent == `MCS_IID_MODEM))
      else $error("modem interrupt not raised");

   ready_release_a: assert property (
      !modemControl[`MCS_MCR_TERM_READY] |=> termReady_n)
      else $error("terminal ready not released");
   request_drive_a: assert property (
      (modemControl[`MCS_MCR_SEND_REQ] && !loopOn) |=> !sendRequest_n)
      else $error("send request not driven low");
   user_a_drive_a: assert property (
      (modemControl[`MCS_MCR_USER_A] && !loopOn) |=> !userOutputA_n)
      else $error("user output a not driven low");
   user_b_drive_a: assert property (
      (modemControl[`MCS_MCR_USER_B] && !loopOn) |=> !userOutputB_n)
      else $error("user output b not driven low");
   tx_pass_a: assert property (
      !loopOn |=> serialTxLine == $past(txShiftOut) && rxShiftIn == $past(serialRxLine))
      else $error("serial path wrong outside loopback");
   reset_clear_a: assert property (disable iff (1'b0)
      $fell(sys_rst) |-> modemControl == `MCS_MCR_RESET && changeFlags == `MCS_MSR_FLAGS_RESET
         && termReady_n && sendRequest_n && userOutputA_n && userOutputB_n)
      else $error("reset state wrong");

   // ==================================================
   // Checks on lines, flags, reads and the modem interrupt
   // Outside a read every event lands at once; inside one the keeper parks it,
   // so the set check leaves read and trailing-edge cycles out
   line_track_a: assert property (
      !loopOn |=> linesQ == $past(pinLines))
      else $error("status lines do not follow pins");
   flag_set_a: assert property (
      (!statusRead && !statusReadQ) |=> (changeFlags & $past(changeEvents)) == $past(changeEvents))
      else $error("change not recorded");
   read_clears_a: assert property (
      flagBus.readEnd |=> (changeFlags & $past(changeFlags)) == 4'h0)
      else $error("flag survived status read");
   read_set_after_a: assert property (
      (flagBus.readEnd && changeFlags == 4'h0)
         |=> (changeFlags & $past(changeEvents)) == $past(changeEvents))
      else $error("change at read end lost");
   status_data_a: assert property (
      statusRead |=> readData == {$past(linesQ), $past(changeFlags)})
      else $error("status read data wrong");
   irq_quiet_a: assert property (
      changeFlags == 4'h0 |-> !irqOut)
      else $error("modem interrupt without a change flag");
   irq_rank_a: assert property (
      higherIrqPending != 3'h0 |-> irqIdent == `MCS_IID_NONE)
      else $error("modem source reported over a higher one");

   loop_enter_c:   cover property (!loopOn ##1 loopOn);
   loop_exit_c:    cover property (loopOn ##1 !loopOn);
   irq_raise_c:    cover property (!irqOut ##1 irqOut);
   ring_end_c:     cover property (changeEvents[`MCS_MSR_RING_END] && !statusRead);
   read_race_c:    cover property (statusRead && changeEvents != 4'h0 ##[1:4] flagBus.readEnd);
endmodule : mcs_modem_control_status

// File: sim/mcs_modem_model.sv
// Purpose: Behavioural modem on the far side of the handshake pins
// Assumes: Bench sets wanted line states with non-blocking writes
// Notes:   Pins move on the falling edge, one cycle after the wish
`timescale 1ns/1ps
module mcs_modem_model (
   // Clock
   input  wire logic       mclk,
   // Wanted states, active high: bit 0 send-clear, 1 set-ready, 2 ring, 3 carrier
   input  wire logic [3:0] lineWant,
   input  wire logic       rxWant,
   // Modem pins, active low
   output logic            clearToSend_n,
   output logic            setReady_n,
   output logic            phoneCallSenseIn_n,
   output logic            carrierDetectIn_n,
   output logic            serialRxLine
);
   // =============================================
   // Pins
   // Start inactive so the first compare after reset sees no change
   initial begin
      {carrierDetectIn_n, phoneCallSenseIn_n, setReady_n, clearToSend_n} = 4'hf;
      serialRxLine = 1'b1;
   end

   // Away from the sampling edge of the device
   always @(negedge mclk) begin
      {carrierDetectIn_n, phoneCallSenseIn_n, setReady_n, clearToSend_n} <= ~lineWant;
      serialRxLine <= rxWant;
   end
endmodule : mcs_modem_model

// File: sim/mcs_modem_control_status_test.sv
// Purpose: Self-checking bench of the modem control/status block
// Assumes: Stimulus at the falling edge, outputs settled before compare
// Notes:   Reference state kept in plain vectors, updated per settled change
`timescale 1ns/1ps
`include "mcs_regs.svh"
module mcs_modem_control_status_test
   import mcs_pkg::*;
;
   // =============================================
   // Signals
   logic       mclk = 1'b0;
   logic       sys_rst = 1'b1;
   logic       chipSel = 1'b0, writeStrobe = 1'b0, readStrobe = 1'b0;
   logic [2:0] regAddr = 3'h0, higherIrqPending = 3'h0;
   mcs_byte_t  writeData = 8'h00, readData, got, d;
   logic       txShiftOut = 1'b1, modemIrqEnable = 1'b0, rxWant = 1'b1;
   logic [3:0] want = 4'h0;
   logic       clearToSend_n, setReady_n, phoneCallSenseIn_n, carrierDetectIn_n, serialRxLine;
   logic       termReady_n, sendRequest_n, userOutputA_n, userOutputB_n;
   logic       serialTxLine, rxShiftIn, irqOut;
   logic [2:0] irqIdent;
   int         errCount = 0, comparisons = 0;
   // Reference state
   logic [4:0] ctl = 5'h00;
   logic [3:0] flg = 4'h0, pend = 4'h0, effOld = 4'h0;

   initial forever #2.5 mclk = ~mclk;

   mcs_modem_control_status i_dut (.mclk(mclk), .sys_rst(sys_rst), .chipSel(chipSel), .regAddr(regAddr),
      .writeStrobe(writeStrobe), .readStrobe(readStrobe), .writeData(writeData), .readData(readData),
      .clearToSend_n(clearToSend_n), .setReady_n(setReady_n), .phoneCallSenseIn_n(phoneCallSenseIn_n),
      .carrierDetectIn_n(carrierDetectIn_n), .termReady_n(termReady_n), .sendRequest_n(sendRequest_n),
      .userOutputA_n(userOutputA_n), .userOutputB_n(userOutputB_n), .txShiftOut(txShiftOut),
      .serialRxLine(serialRxLine), .serialTxLine(serialTxLine), .rxShiftIn(rxShiftIn),
      .modemIrqEnable(modemIrqEnable), .higherIrqPending(higherIrqPending), .irqOut(irqOut), .irqIdent(irqIdent));

   mcs_modem_model i_modem (.mclk(mclk), .lineWant(want), .rxWant(rxWant), .clearToSend_n(clearToSend_n),
      .setReady_n(setReady_n), .phoneCallSenseIn_n(phoneCallSenseIn_n),
      .carrierDetectIn_n(carrierDetectIn_n), .serialRxLine(serialRxLine));

   // =============================================
   // Reference model
   function automatic logic [3:0] eff();
      return ctl[4] ? {ctl[3], ctl[2], ctl[0], ctl[1]} : want;
   endfunction : eff

   task automatic upd(input bit inRead);
      logic [3:0] e, dl;
      e = eff();
      dl = e ^ effOld;
      dl[2] = effOld[2] & ~e[2];
      if (inRead) pend |= dl;
      else flg |= dl;
      effOld = e;
   endtask : upd

   // =============================================
   // Compares and closing
   task automatic chkRd(input mcs_byte_t exp);
      comparisons++;
      if (got !== exp) begin
         errCount++;
         $display("MISMATCH %0t read %h expected %h", $time, got, exp);
      end
   endtask : chkRd

   task automatic chkOut();
      logic [9:0] e, g;
      logic       irq;
      irq = modemIrqEnable & |flg;
      e = {ctl[4] ? 4'hf : ~{ctl[0], ctl[1], ctl[2], ctl[3]}, ctl[4] | txShiftOut,
           ctl[4] ? txShiftOut : serialRxLine, irq,
           (irq && higherIrqPending == 3'h0) ? `MCS_IID_MODEM : `MCS_IID_NONE};
      g = {termReady_n, sendRequest_n, userOutputA_n, userOutputB_n, serialTxLine, rxShiftIn, irqOut, irqIdent};
      comparisons++;
      if (g !== e) begin
         errCount++;
         $display("MISMATCH %0t pins %b expected %b", $time, g, e);
      end
   endtask : chkOut

   task automatic summarize();
      if (errCount == 0 && comparisons > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask : summarize

   // =============================================
   // Bus cycles
   task automatic settle();
      repeat (3) @(negedge mclk);
   endtask : settle

   task automatic wr(input logic [2:0] a, input mcs_byte_t v);
      @(negedge mclk);
      {chipSel, writeStrobe, regAddr, writeData} = {2'b11, a, v};
      @(negedge mclk);
      {chipSel, writeStrobe} = 2'b00;
   endtask : wr

   // A long span lets the lines move while the strobe is still high
   task automatic rd(input logic [2:0] a, input int span, input logic [3:0] during);
      @(negedge mclk);
      {chipSel, readStrobe, regAddr} = {2'b11, a};
      if (span > 1) want <= during;
      @(negedge mclk);
      got = readData;
      repeat (span - 1) @(negedge mclk);
      {chipSel, readStrobe} = 2'b00;
   endtask : rd

   task automatic rdStat(input int span, input logic [3:0] during);
      rd(`MCS_OFS_MODEM_STATUS, span, during);
      chkRd({effOld, flg});
      if (span > 1) upd(1'b1);
      flg = pend & ~flg;
      pend = 4'h0;
      settle();
      chkOut();
   endtask : rdStat

   // =============================================
   // Main sequence
   initial begin
      void'($urandom(16));
      repeat (3) @(posedge mclk);
      @(negedge mclk);
      sys_rst = 1'b0;
      settle();
      chkOut();
      rd(`MCS_OFS_MODEM_CONTROL, 1, want);
      chkRd(8'h00);
      rdStat(1, want);
      for (int i = 0; i < 10; i++) begin
         d = 8'($urandom);
         d[4] = 1'b0;
         modemIrqEnable = 1'($urandom);
         higherIrqPending = 3'($urandom);
         txShiftOut = 1'($urandom);
         rxWant <= 1'($urandom);
         wr(`MCS_OFS_MODEM_CONTROL, d);
         ctl = d[4:0];
         settle();
         chkOut();
         rd(`MCS_OFS_MODEM_CONTROL, 1, want);
         chkRd({3'h0, ctl});
      end
      // Writes to status and to a hole change nothing
      wr(`MCS_OFS_MODEM_STATUS, 8'hff);
      wr(3'h2, 8'($urandom));
      rd(3'h2, 1, want);
      chkRd(8'h00);
      // A strobe without chip select must not write
      @(negedge mclk);
      {chipSel, writeStrobe, regAddr, writeData} = {2'b01, `MCS_OFS_MODEM_CONTROL, 8'h1f};
      @(negedge mclk);
      writeStrobe = 1'b0;
      rd(`MCS_OFS_MODEM_CONTROL, 1, want);
      chkRd({3'h0, ctl});
      for (int i = 0; i < 16; i++) begin
         want <= 4'($urandom);
         modemIrqEnable = 1'($urandom);
         higherIrqPending = 3'($urandom) & {3{i[0]}};
         settle();
         upd(1'b0);
         chkOut();
         if (i % 3 != 2) rdStat(1, want);
      end
      for (int i = 0; i < 12; i++) begin
         want <= 4'($urandom);
         settle();
         upd(1'b0);
         rdStat(3, 4'($urandom));
         rdStat(1, want);
      end
      // Lines held still on entry and exit so only one transition is seen
      for (int i = 0; i < 10; i++) begin
         d = 8'($urandom);
         d[4] = (i != 9);
         modemIrqEnable = 1'b1;
         txShiftOut = 1'($urandom);
         rxWant <= 1'($urandom);
         if (i > 0 && i < 9) want <= 4'($urandom);
         wr(`MCS_OFS_MODEM_CONTROL, d);
         ctl = d[4:0];
         settle();
         upd(1'b0);
         chkOut();
         rdStat(1, want);
      end
      summarize();
   end

   initial begin
      #200us;
      errCount++;
      $display("MISMATCH %0t run did not finish in time", $time);
      summarize();
   end
endmodule : mcs_modem_control_status_test
